// >>> logic/ubcb_top.sv
// Channel B break condition unit: registers, bus watch and break request.
// Assumes L and I bus cycle strobes are one-cycle pulses synchronous to mclk_i.
// Assumes software keeps reserved and prohibited fields at zero.
// Contract
// - Each data mask bit set to 1 drops that data bit from the comparison, 0 keeps it.
// - The five top bits of the cycle select register read zero and are written zero.
// - Master field 000 skips master comparison, bit 0 matches CPU cycles, upper bits stay 0.
// - The master field is ignored whenever the L bus is the selected bus.
// - Bus kind 00 disables, 01 and 11 select the L bus, 10 selects the I bus.
// - Address compare uses bits 31..2, 31..1 or 31..0 for long, word or byte accesses.
// - With data in the condition, address and masked data must both match in one cycle.
// - For word or byte sizes the upper sixteen data and mask bits are ignored.
// - An L bus break is taken after the matching instruction, before the next one.
// - An L bus break with data may land one instruction later; I bus timing is loose.
// - A break on a delayed branch or its slot may land at the branch target.
// - The cycle select register holds master, bus kind, fetch/data, read/write and size.
`timescale 1ns/100ps
module ubcb_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // L bus cycle
    input wire logic lbus_valid_i,
    input wire logic [31:0] lbus_addr_i,
    input wire logic [31:0] lbus_data_i,
    input wire logic [1:0] lbus_size_i,
    input wire logic lbus_fetch_i,
    input wire logic lbus_write_i,
    // Instruction boundary from the core
    input wire logic insn_end_i,
    input wire logic delay_slot_i,
    // I bus cycle
    input wire logic ibus_valid_i,
    input wire logic [31:0] ibus_addr_i,
    input wire logic [31:0] ibus_data_i,
    input wire logic [1:0] ibus_size_i,
    input wire logic ibus_fetch_i,
    input wire logic ibus_write_i,
    input wire logic ibus_cpu_i,
    // Break and interrupt
    output logic break_req_o,
    output logic irq_o
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] channel_b_data_mask;
    logic [15:0] channel_b_cycle_select;
    logic [31:0] channel_b_break_address;
    logic [31:0] channel_b_break_data;
    logic [ubcb_pkg::IRQ_NUM-1:0] irq_status;
    logic [ubcb_pkg::IRQ_NUM-1:0] irq_mask;
    logic [31:0] next_rdata;

    logic [1:0] bus_kind_select;
    logic [2:0] bus_master_select;
    logic use_lbus;
    logic use_ibus;
    logic master_ok;
    logic cycle_hit;
    logic lbus_pending;
    logic lbus_wait_extra;
    logic fire;
    logic status_rd;

    ubcb_cmp_if cif ();

    ubcb_cmp u_cmp (
        .c(cif.cmp)
    );

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------

    // Address and data clear as well; they stay inert until a bus kind is chosen.
    // reset clear: all selects start at 00, so nothing matches.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            channel_b_data_mask <= ubcb_pkg::RST_DATA_MASK;
            channel_b_cycle_select <= ubcb_pkg::RST_CYCLE_SEL;
            channel_b_break_address <= ubcb_pkg::RST_WORD;
            channel_b_break_data <= ubcb_pkg::RST_WORD;
            irq_mask <= '0;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                ubcb_pkg::OFS_DATA_MASK: channel_b_data_mask <= reg_wdata_i;
                // reserved bits: top five bits never store a one.
                ubcb_pkg::OFS_CYCLE_SEL: begin
                    channel_b_cycle_select <= reg_wdata_i[15:0] & ubcb_pkg::CYCLE_SEL_WMASK;
                end
                ubcb_pkg::OFS_BREAK_ADDR: channel_b_break_address <= reg_wdata_i;
                ubcb_pkg::OFS_BREAK_DATA: channel_b_break_data <= reg_wdata_i;
                ubcb_pkg::OFS_IRQ_MASK: irq_mask <= reg_wdata_i[ubcb_pkg::IRQ_NUM-1:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Bus selection and comparison
    // ------------------------------------------------------------------

    // Cycle select layout, as seen by the comparator and by software.
    // Bits 1..0 pick the operand size: 00 off, 01 byte, 10 word, 11 long.
    // Bits 3..2 pick read or write: 00 off, 01 read, 10 write, 11 never matches.
    // Bits 5..4 pick fetch or data: 00 off, 01 fetch, 10 data, 11 never matches.
    // Bits 7..6 pick the bus: 00 off, 01 and 11 the L bus, 10 the I bus.
    // Bits 10..8 pick the master; only bit 0 means anything, and only on the I bus.
    // Bits 15..11 are reserved; they are never stored, so they read back as zero.

    // fields feed the comparator straight from the cycle select register.
    assign bus_kind_select = channel_b_cycle_select[ubcb_pkg::CD_LSB +: 2];
    assign bus_master_select = channel_b_cycle_select[ubcb_pkg::CP_LSB +: 3];

    // bus kind decode: 01 and 11 both pick the L bus.
    always_comb begin
        use_lbus = (bus_kind_select == ubcb_pkg::BK_LBUS) ||
                   (bus_kind_select == ubcb_pkg::BK_LBUS2);
        use_ibus = (bus_kind_select == ubcb_pkg::BK_IBUS);
    end

    // Master bits 2 and 1 are prohibited codes and are left undecoded on purpose.
    // master select: 000 skips, bit 0 admits CPU cycles.
    // L bus ignores master: the field only matters on the I bus.
    always_comb begin
        if (!use_ibus || bus_master_select == 3'b000) begin
            master_ok = 1'b1;
        end else begin
            master_ok = bus_master_select[0] && cif.cpu_master;
        end
    end

    // The selected bus drives the comparator; the other bus is never seen.
    always_comb begin
        cif.addr = use_ibus ? ibus_addr_i : lbus_addr_i;
        cif.data = use_ibus ? ibus_data_i : lbus_data_i;
        cif.size = use_ibus ? ibus_size_i : lbus_size_i;
        cif.is_fetch = use_ibus ? ibus_fetch_i : lbus_fetch_i;
        cif.is_write = use_ibus ? ibus_write_i : lbus_write_i;
        cif.cpu_master = ibus_cpu_i;
        cif.sel = channel_b_cycle_select;
        cif.brk_addr = channel_b_break_address;
        cif.brk_data = channel_b_break_data;
        cif.brk_mask = channel_b_data_mask;
    end

    // all enabled fields: qualify by the chosen bus strobe and master.
    assign cycle_hit = master_ok && cif.hit &&
                       ((use_lbus && lbus_valid_i) || (use_ibus && ibus_valid_i));

    // ------------------------------------------------------------------
    // Break timing
    // ------------------------------------------------------------------

    // The optional deferrals are always taken: a later break is legal in each case,
    // and one fixed timing keeps what the debugger sees predictable.
    // A limitation follows: a second hit before the break restarts the wait.
    // instruction boundary: an L bus hit waits for the instruction end.
    // data breaks: a data hit waits one extra instruction end.
    // delayed branch: the request is held through delay slots.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lbus_pending <= 1'b0;
            lbus_wait_extra <= 1'b0;
        end else if (cycle_hit && use_lbus) begin
            lbus_pending <= 1'b1;
            lbus_wait_extra <= cif.data_used;
        end else if (lbus_pending && insn_end_i && !delay_slot_i) begin
            if (lbus_wait_extra) begin
                lbus_wait_extra <= 1'b0;
            end else begin
                lbus_pending <= 1'b0;
            end
        end
    end

    // I bus hits carry no instruction binding, so they fire at once.
    assign fire = (cycle_hit && use_ibus) ||
                  (lbus_pending && !lbus_wait_extra && insn_end_i && !delay_slot_i);

    // single-cycle request toward the exception logic.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            break_req_o <= 1'b0;
        end else begin
            break_req_o <= fire;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    assign status_rd = reg_rd_i && (reg_addr_i == ubcb_pkg::OFS_IRQ_STATUS);

    // The clear rides on the status read itself, so a hit that lands between a read
    // and a separate clear write can never be lost.
    // A read clears the status, but a hit in that same cycle wins over it.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_status <= '0;
        end else if (fire) begin
            irq_status[ubcb_pkg::IRQ_HIT_BIT] <= 1'b1;
        end else if (status_rd) begin
            irq_status <= '0;
        end
    end

    // Registered level interrupt, one cycle behind the status bit.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------

    // read as zero: the stored value already has the top bits clear.
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (reg_addr_i)
            ubcb_pkg::OFS_DATA_MASK: next_rdata = channel_b_data_mask;
            ubcb_pkg::OFS_CYCLE_SEL: next_rdata = {16'h0000, channel_b_cycle_select};
            ubcb_pkg::OFS_BREAK_ADDR: next_rdata = channel_b_break_address;
            ubcb_pkg::OFS_BREAK_DATA: next_rdata = channel_b_break_data;
            ubcb_pkg::OFS_IRQ_STATUS: next_rdata[ubcb_pkg::IRQ_NUM-1:0] = irq_status;
            ubcb_pkg::OFS_IRQ_MASK: next_rdata[ubcb_pkg::IRQ_NUM-1:0] = irq_mask;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Zero outside the reply cycle lets several slaves share one OR-ed return path.
    // Read data stands only in the cycle after the strobe; zero otherwise.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end
endmodule

// >>> logic/ubcb_pkg.sv
// Package for the channel B break condition block: register offsets, field layout,
// reset values and encodings.
// Assumes a plain register port with word indices and a single CPU clock.
package ubcb_pkg;

    // ------------------------------------------------------------------
    // Register map (word offsets on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_DATA_MASK = 4'h0;
    localparam logic [3:0] OFS_CYCLE_SEL = 4'h1;
    localparam logic [3:0] OFS_BREAK_ADDR = 4'h2;
    localparam logic [3:0] OFS_BREAK_DATA = 4'h3;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h5;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_DATA_MASK = 32'h0000_0000;
    localparam logic [15:0] RST_CYCLE_SEL = 16'h0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Cycle select field positions
    // ------------------------------------------------------------------
    localparam int SZ_LSB = 0;
    localparam int RW_LSB = 2;
    localparam int ID_LSB = 4;
    localparam int CD_LSB = 6;
    localparam int CP_LSB = 8;
    localparam logic [15:0] CYCLE_SEL_WMASK = 16'h07FF;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BK_OFF = 2'b00,
        BK_LBUS = 2'b01,
        BK_IBUS = 2'b10,
        BK_LBUS2 = 2'b11
    } ubcb_kind_e;

    typedef enum logic [1:0] {
        SZ_OFF = 2'b00,
        SZ_BYTE = 2'b01,
        SZ_WORD = 2'b10,
        SZ_LONG = 2'b11
    } ubcb_size_e;

    // Fetch/data and read/write share the 00 = no comparison code.
    localparam logic [1:0] SEL_OFF = 2'b00;
    localparam logic [1:0] SEL_FIRST = 2'b01;
    localparam logic [1:0] SEL_SECOND = 2'b10;

    // Interrupt status bits.
    localparam int IRQ_HIT_BIT = 0;
    localparam int IRQ_NUM = 1;

endpackage

// >>> logic/ubcb_cmp_if.sv
// Interface carrying one bus cycle and the programmed condition to the comparator.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/100ps
interface ubcb_cmp_if;
    logic [31:0] addr;
    logic [31:0] data;
    logic [1:0] size;
    logic is_fetch;
    logic is_write;
    logic cpu_master;
    logic [15:0] sel;
    logic [31:0] brk_addr;
    logic [31:0] brk_data;
    logic [31:0] brk_mask;
    logic hit;
    logic data_used;

    modport top (output addr, data, size, is_fetch, is_write, cpu_master, sel, brk_addr,
                 brk_data, brk_mask, input hit, data_used);
    modport cmp (input addr, data, size, is_fetch, is_write, cpu_master, sel, brk_addr,
                 brk_data, brk_mask, output hit, data_used);
endinterface

// >>> logic/ubcb_cmp.sv
// Combinational condition comparator for one bus cycle of channel B.
// Assumes the caller qualifies hit with a valid bus cycle of the selected bus.
`timescale 1ns/100ps
module ubcb_cmp (
    // Condition and cycle
    ubcb_cmp_if.cmp c
);
    logic [1:0] operand_size_select;
    logic [1:0] read_write_select;
    logic [1:0] fetch_or_data_select;
    logic [31:0] amask;
    logic [31:0] dmask;
    logic addr_ok;
    logic data_ok;
    logic rw_ok;
    logic id_ok;
    logic sz_ok;

    // Field extraction and per-field matches.
    always_comb begin
        operand_size_select = c.sel[ubcb_pkg::SZ_LSB +: 2];
        read_write_select = c.sel[ubcb_pkg::RW_LSB +: 2];
        fetch_or_data_select = c.sel[ubcb_pkg::ID_LSB +: 2];
        // off codes: a 00 field takes no part in the match.
        rw_ok = (read_write_select == ubcb_pkg::SEL_OFF) ||
                (read_write_select == ubcb_pkg::SEL_FIRST && !c.is_write) ||
                (read_write_select == ubcb_pkg::SEL_SECOND && c.is_write);
        id_ok = (fetch_or_data_select == ubcb_pkg::SEL_OFF) ||
                (fetch_or_data_select == ubcb_pkg::SEL_FIRST && c.is_fetch) ||
                (fetch_or_data_select == ubcb_pkg::SEL_SECOND && !c.is_fetch);
        sz_ok = (operand_size_select == ubcb_pkg::SZ_OFF) || (operand_size_select == c.size);
        // address width: low bits dropped by access size.
        unique case (c.size)
            ubcb_pkg::SZ_LONG: amask = 32'hFFFF_FFFC;
            ubcb_pkg::SZ_WORD: amask = 32'hFFFF_FFFE;
            default: amask = 32'hFFFF_FFFF;
        endcase
        addr_ok = ((c.addr ^ c.brk_addr) & amask) == 32'h0000_0000;
        // per-bit mask: a set mask bit drops that data bit.
        dmask = ~c.brk_mask;
        // upper half ignored for word and byte sizes.
        if (operand_size_select != ubcb_pkg::SZ_LONG) begin
            dmask[31:16] = 16'h0000;
        end
        data_ok = ((c.data ^ c.brk_data) & dmask) == 32'h0000_0000;
        // data needs an operand size; then address and data must agree.
        c.data_used = (operand_size_select != ubcb_pkg::SZ_OFF) && !c.is_fetch;
        c.hit = addr_ok && rw_ok && id_ok && sz_ok && (!c.data_used || data_ok);
    end
endmodule

// >>> testbench/ubcb_monitor.sv
// Checker for the channel B break unit, bound to the top module's ports.
// Assumes one clock domain and the register offsets of the package.
`timescale 1ns/100ps
module ubcb_monitor (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // Core events and outputs
    input wire logic ibus_valid_i,
    input wire logic insn_end_i,
    input wire logic delay_slot_i,
    input wire logic break_req_o,
    input wire logic irq_o
);
    logic [15:0] sel;
    logic [31:0] dmask;
    logic imask;
    logic ist;
    logic rd_st;
    logic armed;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    // ------------------------------------------------------------
    // Shadow state
    // ------------------------------------------------------------
    // Status lags the design by one cycle, since only the break pulse is seen here.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sel <= 16'h0;
            dmask <= 32'h0;
            imask <= 1'h0;
            ist <= 1'h0;
            rd_st <= 1'h0;
            armed <= 1'h0;
        end else begin
            rd_st <= reg_rd_i && reg_addr_i == ubcb_pkg::OFS_IRQ_STATUS;
            ist <= break_req_o | (ist & ~rd_st);
            if (reg_wr_i && reg_addr_i == ubcb_pkg::OFS_CYCLE_SEL) begin
                sel <= reg_wdata_i[15:0] & ubcb_pkg::CYCLE_SEL_WMASK;
                armed <= armed | (reg_wdata_i[7:6] != 2'h0);
            end
            if (reg_wr_i && reg_addr_i == ubcb_pkg::OFS_DATA_MASK) begin
                dmask <= reg_wdata_i;
            end
            if (reg_wr_i && reg_addr_i == ubcb_pkg::OFS_IRQ_MASK) begin
                imask <= reg_wdata_i[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_rdata_idle_zero:
        assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data not zero outside a read");
    a_sel_read_back:
        assert property ($past(reg_rd_i) && $past(reg_addr_i) == ubcb_pkg::OFS_CYCLE_SEL
            |-> reg_rdata_o == {16'h0, $past(sel)}) else $error("cycle select read wrong");
    a_mask_read_back:
        assert property ($past(reg_rd_i) && $past(reg_addr_i) == ubcb_pkg::OFS_DATA_MASK
            |-> reg_rdata_o == $past(dmask)) else $error("data mask read wrong");
    a_unmapped_read_zero:
        assert property ($past(reg_rd_i) && $past(reg_addr_i) > ubcb_pkg::OFS_IRQ_MASK
            |-> reg_rdata_o == 32'h0) else $error("unmapped read not zero");
    a_no_break_unarmed:
        assert property (!armed |-> !break_req_o) else $error("break before any bus kind set");
    a_ibus_break_cause:
        assert property (break_req_o && sel[7:6] == 2'h2 && $stable(sel)
            |-> $past(ibus_valid_i)) else $error("I bus break without a bus cycle");
    a_lbus_insn_edge:
        assert property (break_req_o && sel[6] && $stable(sel)
            |-> $past(insn_end_i) && !$past(delay_slot_i)) else $error("L bus break off boundary");
    a_irq_follows_status:
        assert property (irq_o == (ist & $past(imask))) else $error("interrupt level wrong");
endmodule

bind ubcb_top ubcb_monitor i_mon (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ibus_valid_i(ibus_valid_i), .insn_end_i(insn_end_i), .delay_slot_i(delay_slot_i),
    .break_req_o(break_req_o), .irq_o(irq_o)
);

// >>> testbench/ubcb_cpu_model.sv
// CPU side model: drives L and I bus cycles and instruction boundaries.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/100ps
module ubcb_cpu_model (
    // Clock
    input wire logic mclk_i,
    // Cycles packed as valid, address, data, size, fetch, write, plus CPU master on the I bus only
    output logic [68:0] lbus_o,
    output logic [69:0] ibus_o,
    // Instruction boundary
    output logic insn_end_o,
    output logic delay_slot_o
);
    initial begin
        lbus_o = 69'h0;
        ibus_o = 70'h0;
        insn_end_o = 1'h0;
        delay_slot_o = 1'h0;
    end

    // ------------------------------------------------------------
    // Bus cycle tasks
    // ------------------------------------------------------------
    // A cycle lasts one clock; released lines flip so stale data never looks valid.
    task automatic cyc(input logic on_i, input logic [31:0] a, d, input logic [1:0] sz,
                       input logic [2:0] fwc);
        @(posedge mclk_i);
        if (on_i) begin
            ibus_o <= {1'h1, a, d, sz, fwc};
        end else begin
            lbus_o <= {1'h1, a, d, sz, fwc[2:1]};
        end
        @(posedge mclk_i);
        lbus_o <= {1'h0, ~lbus_o[67:0]};
        ibus_o <= {1'h0, ~ibus_o[68:0]};
    endtask

    // One instruction finishes; the slot flag is only meaningful beside the pulse.
    task automatic insn(input logic slot);
        @(posedge mclk_i);
        insn_end_o <= 1'h1;
        delay_slot_o <= slot;
        @(posedge mclk_i);
        insn_end_o <= 1'h0;
        delay_slot_o <= ~slot;
    endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the channel B break unit.
// Assumes the CPU model and the bound checker beside the design.
`timescale 1ns/100ps
module testbench;
    logic mclk_i;
    logic rst_b_i;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [68:0] lb;
    logic [69:0] ib;
    logic insn_end;
    logic slot;
    logic brk;
    logic irq;
    int err_total;
    int checks;

    ubcb_top i_dut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .lbus_valid_i(lb[68]), .lbus_addr_i(lb[67:36]), .lbus_data_i(lb[35:4]),
        .lbus_size_i(lb[3:2]), .lbus_fetch_i(lb[1]), .lbus_write_i(lb[0]),
        .insn_end_i(insn_end), .delay_slot_i(slot),
        .ibus_valid_i(ib[69]), .ibus_addr_i(ib[68:37]), .ibus_data_i(ib[36:5]),
        .ibus_size_i(ib[4:3]), .ibus_fetch_i(ib[2]), .ibus_write_i(ib[1]), .ibus_cpu_i(ib[0]),
        .break_req_o(brk), .irq_o(irq)
    );
    ubcb_cpu_model i_cpu (.mclk_i(mclk_i), .lbus_o(lb), .ibus_o(ib), .insn_end_o(insn_end),
        .delay_slot_o(slot));

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge mclk_i);
        reg_wr <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge mclk_i);
        reg_rd <= 1'h0;
        #1 chk("reg_read", e, reg_rdata);
    endtask

    // One bus cycle, n instruction ends, then the break must fire once or not at all.
    task automatic hit(input logic on_i, input logic [31:0] a, d, input logic [1:0] sz,
                       input logic [2:0] fwc, input int n, input logic e);
        i_cpu.cyc(on_i, a, d, sz, fwc);
        for (int k = 0; k < n; k++) begin
            #1 chk("early_break", 32'h0, {31'h0, brk});
            i_cpu.insn(1'h0);
        end
        #1 chk("break", {31'h0, e}, {31'h0, brk});
        @(posedge mclk_i);
        #1 chk("break_pulse", 32'h0, {31'h0, brk});
    endtask

    task automatic complete_run();
        $display("Checks %0d, errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd_chk(ubcb_pkg::OFS_DATA_MASK, 32'h0);
        rd_chk(ubcb_pkg::OFS_CYCLE_SEL, 32'h0);
        wr(ubcb_pkg::OFS_CYCLE_SEL, 32'hFFFF_F8FF);
        rd_chk(ubcb_pkg::OFS_CYCLE_SEL, 32'h0000_00FF);
        wr(ubcb_pkg::OFS_DATA_MASK, 32'hA5A5_5A5A);
        rd_chk(ubcb_pkg::OFS_DATA_MASK, 32'hA5A5_5A5A);
        rd_chk(4'hF, 32'h0);
        wr(ubcb_pkg::OFS_CYCLE_SEL, 32'h0);
    endtask

    task automatic t_ibus();
        hit(1'h1, 32'h1000, 32'h0, 2'h3, 3'h1, 0, 1'h0);
        wr(ubcb_pkg::OFS_BREAK_ADDR, 32'h0000_1003);
        wr(ubcb_pkg::OFS_IRQ_MASK, 32'h1);
        wr(ubcb_pkg::OFS_CYCLE_SEL, 32'h0000_0180);
        hit(1'h1, 32'h1000, 32'h0, 2'h3, 3'h1, 0, 1'h1);
        chk("irq_set", 32'h1, {31'h0, irq});
        rd_chk(ubcb_pkg::OFS_IRQ_STATUS, 32'h1);
        rd_chk(ubcb_pkg::OFS_IRQ_STATUS, 32'h0);
        chk("irq_clear", 32'h0, {31'h0, irq});
        wr(ubcb_pkg::OFS_IRQ_MASK, 32'h0);
        hit(1'h1, 32'h1002, 32'h0, 2'h2, 3'h1, 0, 1'h1);
        hit(1'h1, 32'h1003, 32'h0, 2'h1, 3'h1, 0, 1'h1);
        hit(1'h1, 32'h1002, 32'h0, 2'h1, 3'h1, 0, 1'h0);
        hit(1'h1, 32'h1000, 32'h0, 2'h3, 3'h0, 0, 1'h0);
        wr(ubcb_pkg::OFS_CYCLE_SEL, 32'h0000_0080);
        hit(1'h1, 32'h1000, 32'h0, 2'h3, 3'h0, 0, 1'h1);
        hit(1'h0, 32'h1000, 32'h0, 2'h3, 3'h0, 0, 1'h0);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rd_chk(ubcb_pkg::OFS_IRQ_STATUS, 32'h1);
    endtask

    task automatic t_lbus();
        wr(ubcb_pkg::OFS_CYCLE_SEL, 32'h0000_01D4);
        hit(1'h0, 32'h1000, 32'h0, 2'h3, 3'h4, 1, 1'h1);
        hit(1'h0, 32'h1000, 32'h0, 2'h3, 3'h0, 2, 1'h0);
        hit(1'h0, 32'h1000, 32'h0, 2'h3, 3'h6, 2, 1'h0);
        i_cpu.cyc(1'h0, 32'h1000, 32'h0, 2'h3, 3'h4);
        i_cpu.insn(1'h1);
        #1 chk("slot_defer", 32'h0, {31'h0, brk});
        i_cpu.insn(1'h0);
        #1 chk("slot_break", 32'h1, {31'h0, brk});
    endtask

    // Bus data repeat across lanes so the lane choice of the design does not matter.
    task automatic t_data();
        wr(ubcb_pkg::OFS_BREAK_DATA, 32'hFFFF_1234);
        wr(ubcb_pkg::OFS_DATA_MASK, 32'hABCD_000F);
        wr(ubcb_pkg::OFS_CYCLE_SEL, 32'h0000_006A);
        hit(1'h0, 32'h1002, 32'h1235_1235, 2'h2, 3'h2, 2, 1'h1);
        hit(1'h0, 32'h1002, 32'h0234_0234, 2'h2, 3'h2, 2, 1'h0);
        hit(1'h0, 32'h1000, 32'h1234_1234, 2'h2, 3'h2, 2, 1'h0);
        hit(1'h0, 32'h1002, 32'h1235_1235, 2'h3, 3'h2, 2, 1'h0);
        wr(ubcb_pkg::OFS_BREAK_DATA, 32'h0000_5A5A);
        wr(ubcb_pkg::OFS_DATA_MASK, 32'h0000_0101);
        wr(ubcb_pkg::OFS_CYCLE_SEL, 32'h0000_0069);
        hit(1'h0, 32'h1003, 32'h5B5B_5B5B, 2'h1, 3'h2, 2, 1'h1);
    endtask

    // Clock at 250 MHz.
    initial begin
        mclk_i = 1'h0;
        forever #2 mclk_i = ~mclk_i;
    end

    // The scenarios need under a thousand cycles, so ten thousand means a hang.
    initial begin
        #40000;
        err_total++;
        complete_run();
    end

    initial begin
        rst_b_i = 1'h0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        repeat (10) @(posedge mclk_i);
        rst_b_i <= 1'h1;
        t_regs();
        t_ibus();
        t_lbus();
        t_data();
        complete_run();
    end
endmodule
